// ### asp_serial_port.sv
`timescale 1ns/1ps
module asp_serial_port #(
   parameter int WINDOW_DELAY_CYCLES = asp_pkg::WINDOW_DELAY_CYCLES
) (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // serial pins
   input wire logic host_shift_clock_i,
   input wire logic host_serial_in_i,
   input wire logic chip_select_n_i,
   input wire logic conversion_start_i,
   input wire logic interface_ddr_sel_i,
   output logic result_serial_out_o,
   output logic result_serial_out_oe_o,
   output logic echoed_shift_clock_o,
   output logic echoed_shift_clock_oe_o,
   // converter core
   input wire logic busy_i,
   input wire logic result_valid_i,
   output logic result_ready_o,
   input wire logic [asp_pkg::RES_W-1:0] result_data_i,
   output logic [asp_pkg::FLD_W-1:0] channel_select_field_o,
   output logic [asp_pkg::FLD_W-1:0] range_code_o,
   output logic cfg_load_o,
   // status
   output logic window_open_o
);
   localparam int CNT_W = $clog2(WINDOW_DELAY_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WINDOW_DELAY_CYCLES - 1);

   function automatic logic [asp_pkg::CFG_W-1:0] word_cfg(
      input logic [asp_pkg::WORD_W-1:0] w);
      word_cfg = {w[asp_pkg::CH_HI:asp_pkg::CH_LO],
                  w[asp_pkg::RNG_HI:asp_pkg::RNG_LO]};
   endfunction

   function automatic logic [asp_pkg::PTR_W-1:0] ptr_wrap(
      input logic [asp_pkg::LEN_W-1:0] nxt,
      input logic [asp_pkg::LEN_W-1:0] len);
      ptr_wrap = (nxt >= len) ? '0 : nxt[asp_pkg::PTR_W-1:0];
   endfunction

   function automatic logic pkt_bit(input logic [asp_pkg::PKT_W-1:0] p,
                                    input logic [asp_pkg::IDX_W-1:0] i);
      pkt_bit = p[asp_pkg::PKT_LAST - i];
   endfunction

   logic [asp_pkg::PIN_W-1:0] pins_raw;
   logic [asp_pkg::PIN_W-1:0] pins_s;
   asp_pkg::asp_state_t state_r;
   logic [CNT_W-1:0] pwr_cnt_r;
   logic sck_prev_r;
   logic cnv_prev_r;
   logic busy_prev_r;
   logic sck_s;
   logic sck_rise;
   logic sck_fall;
   logic ddr_mode;
   logic cs_act;
   logic shift_evt;
   logic cnv_rise;
   logic busy_fall;
   logic in_win;
   logic conv_take;
   logic [asp_pkg::WORD_W-1:0] in_shift_r;
   logic [asp_pkg::BIT_W-1:0] in_cnt_r;
   logic [asp_pkg::WORD_W-1:0] new_word;
   logic word_done;
   logic accept;
   logic [asp_pkg::LEN_W-1:0] new_cnt_r;
   logic [asp_pkg::CFG_W-1:0] seq_mem [asp_pkg::SEQ_DEPTH];
   logic [asp_pkg::LEN_W-1:0] seq_len_r;
   logic [asp_pkg::PTR_W-1:0] seq_ptr_r;
   logic [asp_pkg::CFG_W-1:0] cfg_r;
   logic cfg_load_r;
   logic [asp_pkg::PKT_W-1:0] pkt_r;
   logic [asp_pkg::PKT_W-1:0] load_pkt;
   logic [asp_pkg::IDX_W-1:0] pkt_idx_r;
   logic [asp_pkg::IDX_W-1:0] idx_nxt;
   logic sdo_r;
   logic echo_r;
   logic oe_r;
   logic buf_out_valid;
   logic [asp_pkg::PKT_W-1:0] buf_out_data;

   assign pins_raw = {interface_ddr_sel_i, conversion_start_i,
                      chip_select_n_i, host_serial_in_i, host_shift_clock_i};

   asp_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .async_i(pins_raw),
      .sync_o(pins_s)
   );

   assign sck_s = pins_s[asp_pkg::PIN_SCK];
   assign sck_rise = sck_s & ~sck_prev_r;
   assign sck_fall = ~sck_s & sck_prev_r;
   assign ddr_mode = pins_s[asp_pkg::PIN_DDR];
   // bus live only with select low
   assign cs_act = ~pins_s[asp_pkg::PIN_CS];
   // a stray falling edge at select assertion relies on idle low
   assign shift_evt = cs_act & (sck_rise | (ddr_mode & sck_fall));
   assign cnv_rise = pins_s[asp_pkg::PIN_CNV] & ~cnv_prev_r;
   assign busy_fall = busy_prev_r & ~busy_i;
   assign in_win = (state_r == asp_pkg::ST_WINDOW);
   assign conv_take = clk_en_i & in_win & cnv_rise;
   assign window_open_o = in_win;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sck_prev_r <= 1'b0;
         cnv_prev_r <= 1'b0;
         busy_prev_r <= 1'b0;
      end else if (clk_en_i) begin
         sck_prev_r <= sck_s;
         cnv_prev_r <= pins_s[asp_pkg::PIN_CNV];
         busy_prev_r <= busy_i;
      end
   end

   // window after power-up delay and on busy fall
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r <= asp_pkg::ST_POWERUP;
         pwr_cnt_r <= '0;
      end else if (clk_en_i) begin
         case (state_r)
            asp_pkg::ST_POWERUP: begin
               if (pwr_cnt_r == CNT_LAST) begin
                  state_r <= asp_pkg::ST_WINDOW;
               end else begin
                  pwr_cnt_r <= pwr_cnt_r + CNT_W'(1);
               end
            end
            asp_pkg::ST_WINDOW: begin
               if (cnv_rise) begin
                  state_r <= asp_pkg::ST_CONVERT;
               end
            end
            asp_pkg::ST_CONVERT: begin
               if (busy_fall) begin
                  state_r <= asp_pkg::ST_WINDOW;
               end
            end
            default: begin
               state_r <= asp_pkg::ST_POWERUP;
            end
         endcase
      end
   end

   assign new_word = {in_shift_r[asp_pkg::WORD_W-2:0],
                      pins_s[asp_pkg::PIN_SDI]};
   // words taken only while the window is open
   assign word_done = shift_evt & in_win & ~cnv_rise &
                      (in_cnt_r == asp_pkg::WORD_LAST_BIT);
   // cap at sixteen, skip invalid words
   assign accept = word_done & new_word[asp_pkg::VALID_BIT] &
                   (new_cnt_r != asp_pkg::SEQ_FULL);

   // partial word dropped when conversion starts
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         in_shift_r <= '0;
         in_cnt_r <= '0;
      end else if (clk_en_i) begin
         if (conv_take || !in_win) begin
            in_cnt_r <= '0;
         end else if (shift_evt) begin
            in_shift_r <= new_word;
            in_cnt_r <= in_cnt_r + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         new_cnt_r <= '0;
      end else if (clk_en_i) begin
         if (conv_take || !in_win) begin
            new_cnt_r <= '0;
         end else if (accept) begin
            new_cnt_r <= new_cnt_r + 5'h01;
         end
      end
   end

   // old sequence is overwritten in place; only the head is read at start
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         for (int i = 0; i < asp_pkg::SEQ_DEPTH; i++) begin
            seq_mem[i] <= {i[asp_pkg::FLD_W-1:0], asp_pkg::RANGE_DEFAULT};
         end
      end else if (clk_en_i && accept) begin
         seq_mem[new_cnt_r[asp_pkg::PTR_W-1:0]] <= word_cfg(new_word);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         seq_len_r <= asp_pkg::DEFAULT_LEN;
         seq_ptr_r <= '0;
         cfg_r <= {{asp_pkg::FLD_W{1'b0}}, asp_pkg::RANGE_DEFAULT};
         cfg_load_r <= 1'b0;
      end else if (clk_en_i) begin
         cfg_load_r <= conv_take;
         if (conv_take) begin
            if (new_cnt_r != 5'h00) begin
               seq_len_r <= new_cnt_r;
               cfg_r <= seq_mem[0];
               seq_ptr_r <= ptr_wrap(5'h01, new_cnt_r);
            end else begin
               cfg_r <= seq_mem[seq_ptr_r];
               seq_ptr_r <= ptr_wrap({1'b0, seq_ptr_r} + 5'h01, seq_len_r);
            end
         end
      end
   end

   // range code straight to the analog side
   assign channel_select_field_o = cfg_r[asp_pkg::CFG_W-1:asp_pkg::FLD_W];
   assign range_code_o = cfg_r[asp_pkg::FLD_W-1:0];
   assign cfg_load_o = cfg_load_r;

   // two entries let a result wait while the previous packet still shifts
   // result, channel, range packed msb first
   asp_skid u_skid (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(result_valid_i),
      .in_ready_o(result_ready_o),
      .in_data_i({result_data_i, cfg_r}),
      .out_valid_o(buf_out_valid),
      .out_ready_i(busy_fall),
      .out_data_o(buf_out_data)
   );

   assign load_pkt = buf_out_valid ? buf_out_data : pkt_r;
   // packet repeats after the last bit
   assign idx_nxt = (pkt_idx_r == asp_pkg::PKT_LAST) ? '0 :
                    pkt_idx_r + 5'h01;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pkt_r <= '0;
         pkt_idx_r <= '0;
         sdo_r <= 1'b0;
         echo_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (clk_en_i) begin
         oe_r <= cs_act;
         if (busy_fall) begin
            // load finished result, echo forced low
            pkt_r <= load_pkt;
            pkt_idx_r <= '0;
            sdo_r <= pkt_bit(load_pkt, '0);
            echo_r <= 1'b0;
         end else if (shift_evt) begin
            pkt_idx_r <= idx_nxt;
            sdo_r <= pkt_bit(pkt_r, idx_nxt);
            // echo follows or halves the clock
            echo_r <= ddr_mode ? sck_s : ~echo_r;
         end
      end
   end

   assign result_serial_out_o = sdo_r;
   assign echoed_shift_clock_o = echo_r;
   assign result_serial_out_oe_o = oe_r;
   assign echoed_shift_clock_oe_o = oe_r;

   logic [asp_pkg::PTR_W-1:0] acc_idx;
   logic [asp_pkg::CFG_W-1:0] acc_cfg;
   logic [asp_pkg::CFG_W-1:0] head_cfg;
   logic [asp_pkg::CFG_W-1:0] cur_cfg;
   assign acc_idx = new_cnt_r[asp_pkg::PTR_W-1:0];
   assign acc_cfg = word_cfg(new_word);
   assign head_cfg = seq_mem[0];
   assign cur_cfg = seq_mem[seq_ptr_r];

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   chk_default_seq: assert property (
      $fell(reset_i) |-> seq_len_r == asp_pkg::DEFAULT_LEN &&
         seq_ptr_r == '0 && seq_mem[asp_pkg::NUM_CH-1] == 6'h3f)
      else $error("default sequence wrong after reset");
   chk_word_cap: assert property (
      clk_en_i && word_done && new_cnt_r == asp_pkg::SEQ_FULL
      |=> new_cnt_r == asp_pkg::SEQ_FULL)
      else $error("word beyond sixteen accepted");
   chk_invalid_drop: assert property (
      clk_en_i && word_done && !new_word[asp_pkg::VALID_BIT]
      |=> $stable(new_cnt_r))
      else $error("invalid word counted");
   chk_word_store: assert property (
      clk_en_i && accept |=> seq_mem[$past(acc_idx)] == $past(acc_cfg) &&
         new_cnt_r == $past(new_cnt_r) + 5'h01)
      else $error("accepted word not stored");
   chk_partial_drop: assert property (
      conv_take |=> in_cnt_r == '0 && new_cnt_r == '0 &&
         state_r == asp_pkg::ST_CONVERT)
      else $error("partial word survived conversion start");
   chk_commit_new: assert property (
      conv_take && new_cnt_r != 5'h00 |=> cfg_r == $past(head_cfg) &&
         seq_len_r == $past(new_cnt_r) && cfg_load_o)
      else $error("new sequence head not applied");
   chk_advance_old: assert property (
      conv_take && new_cnt_r == 5'h00 |=> cfg_r == $past(cur_cfg) &&
         $stable(seq_len_r) && (seq_ptr_r != $past(seq_ptr_r) ||
         seq_len_r == 5'h01))
      else $error("pointer did not advance");
   chk_load_pkt: assert property (
      clk_en_i && busy_fall && buf_out_valid |=> pkt_r == $past(buf_out_data)
         && sdo_r == pkt_r[asp_pkg::PKT_W-1] && !echo_r)
      else $error("packet not loaded on busy fall");
   chk_bus_release: assert property (
      clk_en_i && !cs_act |=> !result_serial_out_oe_o &&
         !echoed_shift_clock_oe_o)
      else $error("outputs driven with select high");
   chk_packet_wrap: assert property (
      clk_en_i && shift_evt && !busy_fall &&
         pkt_idx_r == asp_pkg::PKT_LAST
      |=> pkt_idx_r == '0 && sdo_r == pkt_r[asp_pkg::PKT_W-1])
      else $error("packet did not repeat");
   chk_se_fall_idle: assert property (
      clk_en_i && !ddr_mode && sck_fall && !busy_fall && !cnv_rise && in_win
      |=> $stable(in_cnt_r) && $stable(pkt_idx_r))
      else $error("falling edge used in single-ended mode");
   chk_window_delay: assert property (
      clk_en_i && state_r == asp_pkg::ST_POWERUP && pwr_cnt_r == CNT_LAST
      |=> window_open_o)
      else $error("window did not open after delay");
   chk_freeze_hold: assert property (
      !clk_en_i |=> $stable(state_r) && $stable(cfg_r) &&
         $stable(seq_ptr_r) && $stable(pkt_idx_r) && $stable(new_cnt_r))
      else $error("state moved while clock enable low");

   cov_full_seq: cover property (clk_en_i && accept &&
      new_cnt_r == asp_pkg::SEQ_FULL - 5'h01);
   cov_commit: cover property (conv_take && new_cnt_r != 5'h00);
   cov_wrap: cover property (shift_evt && pkt_idx_r == asp_pkg::PKT_LAST);
   cov_ddr: cover property (shift_evt && ddr_mode && sck_fall);
endmodule

// ### asp_pkg.sv
package asp_pkg;
   // control word and packet layout
   localparam int WORD_W = 8;
   localparam int PKT_W = 24;
   localparam int RES_W = 18;
   localparam int FLD_W = 3;
   localparam int CFG_W = 6;
   localparam int VALID_BIT = 7;
   localparam int CH_HI = 5;
   localparam int CH_LO = 3;
   localparam int RNG_HI = 2;
   localparam int RNG_LO = 0;
   localparam logic [2:0] WORD_LAST_BIT = 3'h7;
   localparam logic [4:0] PKT_LAST = 5'h17;
   // sequencer
   localparam int SEQ_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int LEN_W = 5;
   localparam int NUM_CH = 8;
   localparam int BIT_W = 3;
   localparam int IDX_W = 5;
   localparam logic [4:0] SEQ_FULL = 5'h10;
   localparam logic [4:0] DEFAULT_LEN = 5'h08;
   localparam logic [2:0] RANGE_DEFAULT = 3'h7;
   // result buffer
   localparam int BUF_DEPTH = 2;
   localparam logic [1:0] BUF_FULL = 2'h2;
   // pin vector positions
   localparam int PIN_W = 5;
   localparam int PIN_SCK = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_CS = 2;
   localparam int PIN_CNV = 3;
   localparam int PIN_DDR = 4;
   // timing
   localparam longint CLK_HZ = 40_000_000;
   localparam longint WINDOW_DELAY_MS = 10;
   localparam int WINDOW_DELAY_CYCLES = int'(CLK_HZ * WINDOW_DELAY_MS / 1000);

   typedef enum logic [2:0] {
      ST_POWERUP = 3'b001,
      ST_WINDOW  = 3'b010,
      ST_CONVERT = 3'b100
   } asp_state_t;
endpackage

// ### asp_sync.sv
`timescale 1ns/1ps
module asp_sync (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // pins
   input wire logic [asp_pkg::PIN_W-1:0] async_i,
   output logic [asp_pkg::PIN_W-1:0] sync_o
);
   // select idles high; a zero reset would fake a select after reset
   localparam logic [asp_pkg::PIN_W-1:0] PIN_IDLE =
      {{(asp_pkg::PIN_W-1){1'b0}}, 1'b1} << asp_pkg::PIN_CS;
   logic [asp_pkg::PIN_W-1:0] meta_r;
   logic [asp_pkg::PIN_W-1:0] sync_r;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_r <= PIN_IDLE;
         sync_r <= PIN_IDLE;
      end else if (clk_en_i) begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;
endmodule

// ### asp_skid.sv
`timescale 1ns/1ps
module asp_skid (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [asp_pkg::PKT_W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [asp_pkg::PKT_W-1:0] out_data_o
);
   logic [asp_pkg::PKT_W-1:0] mem_r [asp_pkg::BUF_DEPTH];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;

   assign in_ready_o = (count_r != asp_pkg::BUF_FULL);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = clk_en_i & in_valid_i & in_ready_o;
   assign pop = clk_en_i & out_ready_i & out_valid_o;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         for (int i = 0; i < asp_pkg::BUF_DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end
endmodule

// ### asp_host_model.sv
`timescale 1ns/1ps
module asp_host_model (
   // monitor clock
   input wire logic clk_sys_i,
   // device side
   input wire logic result_serial_out_i,
   input wire logic result_serial_out_oe_i,
   input wire logic echoed_shift_clock_i,
   // host pins
   output logic host_shift_clock_o,
   output logic host_serial_in_o,
   output logic chip_select_n_o
);
   logic rx_q[$];
   logic echo_r;
   logic sdo_r;
   logic oe_seen;

   initial begin
      host_shift_clock_o = 1'b0;
      host_serial_in_o = 1'b0;
      chip_select_n_o = 1'b1;
      echo_r = 1'b0;
      sdo_r = 1'b0;
      oe_seen = 1'b0;
   end

   // capture on echo edges
   // echo and data move together, so keep the bit that stood before
   always @(posedge clk_sys_i) begin
      if (!chip_select_n_o && echoed_shift_clock_i !== echo_r)
         rx_q.push_back(sdo_r);
      if (!chip_select_n_o && result_serial_out_oe_i === 1'b1)
         oe_seen = 1'b1;
      echo_r = echoed_shift_clock_i;
      sdo_r = result_serial_out_i;
   end

   task automatic shift(input logic tx[$], input logic ddr);
      // step off the sampling edge so pin changes never race it
      #3;
      rx_q = {};
      oe_seen = 1'b0;
      chip_select_n_o = 1'b0;
      #200;
      foreach (tx[i]) begin
         host_serial_in_o = tx[i];
         if (ddr) begin
            // ddr bit counts are even, clock ends low
            #50 host_shift_clock_o = ~host_shift_clock_o;
            #50;
         end else begin
            #100 host_shift_clock_o = 1'b1;
            #100 host_shift_clock_o = 1'b0;
         end
      end
      #200;
      chip_select_n_o = 1'b1;
      // released data line shows the inverse of its last level
      host_serial_in_o = ~host_serial_in_o;
      #200;
   endtask
endmodule

// ### asp_serial_port_tb.sv
`timescale 1ns/1ps
module asp_serial_port_tb;
   logic clk_sys_i, reset_i, conv_start, ddr_sel, busy, res_valid;
   logic [17:0] res_data;
   logic clk_en;
   wire logic sck, host_serial_in, cs_n, sdo_w;
   logic result_serial_out, sdo_oe, echo, echo_oe, res_ready, cfg_load, win_open;
   logic [2:0] ch, rng;
   logic [23:0] cur_pkt;
   logic [23:0] pkt_q[$];
   logic txq[$];
   int err_total, tests_run, n, i;

   // shared pin resolved from the output enable
   // no pull on the line: a released pin shows the inverse level
   assign sdo_w = sdo_oe ? result_serial_out : ~result_serial_out;

   asp_serial_port #(.WINDOW_DELAY_CYCLES(20)) asp_serial_port_inst (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en),
      .host_shift_clock_i(sck), .host_serial_in_i(host_serial_in),
      .chip_select_n_i(cs_n), .conversion_start_i(conv_start),
      .interface_ddr_sel_i(ddr_sel), .result_serial_out_o(result_serial_out),
      .result_serial_out_oe_o(sdo_oe), .echoed_shift_clock_o(echo),
      .echoed_shift_clock_oe_o(echo_oe), .busy_i(busy),
      .result_valid_i(res_valid), .result_ready_o(res_ready),
      .result_data_i(res_data), .channel_select_field_o(ch),
      .range_code_o(rng), .cfg_load_o(cfg_load),
      .window_open_o(win_open));

   asp_host_model host (
      .clk_sys_i(clk_sys_i), .result_serial_out_i(sdo_w),
      .result_serial_out_oe_i(sdo_oe), .echoed_shift_clock_i(echo),
      .host_shift_clock_o(sck), .host_serial_in_o(host_serial_in),
      .chip_select_n_o(cs_n));

   task automatic results;
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic tmo(input string nm);
      err_total++;
      $display("mismatch %s expected event seen timeout", nm);
      results();
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_fld(input string nm, input logic [2:0] e,
                          input logic [2:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pkt(input string nm, input logic [23:0] e,
                          input logic [23:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wait_hi(ref logic s, input string nm);
      int k;
      for (k = 0; s !== 1'b1; k++) begin
         if (k > 4000) tmo(nm);
         @(posedge clk_sys_i);
         #1;
      end
   endtask

   task automatic put(input logic [7:0] w, input int nb);
      for (int k = 7; k > 7 - nb; k--) txq.push_back(w[k]);
   endtask

   task automatic conv(input logic [2:0] c, input logic [2:0] r,
                       input int np, input logic [17:0] d);
      int k;
      int t;
      @(posedge clk_sys_i);
      conv_start <= 1'b1;
      wait_hi(cfg_load, "cfg_load");
      chk_fld("range", r, rng);
      chk_fld("channel", c, ch);
      chk_bit("window_open", 1'b0, win_open);
      @(posedge clk_sys_i);
      conv_start <= 1'b0;
      busy <= 1'b1;
      for (k = 0; k < np; k++) begin
         @(posedge clk_sys_i);
         res_valid <= 1'b1;
         res_data <= d + 18'(k);
         for (t = 0; t < 50; t++) begin
            @(posedge clk_sys_i);
            if (res_ready === 1'b1) break;
         end
         if (t == 50) tmo("result_ready");
         res_valid <= 1'b0;
         pkt_q.push_back({d + 18'(k), c, r});
      end
      repeat (4) @(posedge clk_sys_i);
      if (np == 2) chk_bit("result_ready", 1'b0, res_ready);
      busy <= 1'b0;
      if (pkt_q.size() > 0) cur_pkt = pkt_q.pop_front();
      wait_hi(win_open, "window_open");
   endtask

   task automatic rd(input logic d);
      int k;
      @(posedge clk_sys_i);
      ddr_sel <= d;
      repeat (4) @(posedge clk_sys_i);
      host.shift(txq, d);
      chk_bit("oe_driving", 1'b1, host.oe_seen);
      chk_bit("oe_idle", 1'b0, sdo_oe);
      chk_bit("echo_oe_idle", 1'b0, echo_oe);
      chk_pkt("bit_count", 24'(txq.size()), 24'(host.rx_q.size()));
      for (k = 0; k < host.rx_q.size(); k++)
         chk_bit("packet_bit", cur_pkt[23 - k % 24], host.rx_q[k]);
      txq = {};
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      reset_i = 1'b1;
      clk_en = 1'b1;
      conv_start = 1'b0;
      ddr_sel = 1'b0;
      busy = 1'b0;
      res_valid = 1'b0;
      res_data = 18'h00000;
      cur_pkt = 24'h000000;
      err_total = 0;
      tests_run = 0;
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1;
      chk_fld("reset_range", 3'h7, rng);
      chk_fld("reset_channel", 3'h0, ch);
      for (n = 0; win_open !== 1'b1 && n < 100; n++) begin
         @(posedge clk_sys_i);
         #1;
      end
      chk_bit("window_delay", 1'b1, n >= 19 && n <= 21);
      // a start offered while frozen must leave no trace
      @(posedge clk_sys_i);
      clk_en <= 1'b0;
      conv_start <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      chk_bit("freeze_load", 1'b0, cfg_load);
      chk_bit("freeze_window", 1'b1, win_open);
      chk_fld("freeze_channel", 3'h0, ch);
      conv_start <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      clk_en <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      chk_bit("thaw_window", 1'b1, win_open);
      // default walk over eight channels, then wrap
      for (i = 0; i < 9; i++) begin
         conv(3'(i % 8), 3'h7, 1, 18'h2a5a0 + 18'(i));
         repeat (24) txq.push_back(1'b0);
         rd(1'b0);
      end
      // valid, invalid, valid, then a partial word cut by the start
      put(8'h9a, 8);
      put(8'h1f, 8);
      put(8'ha9, 8);
      put(8'hff, 4);
      rd(1'b1);
      conv(3'h3, 3'h2, 1, 18'h00011);
      conv(3'h5, 3'h1, 0, 18'h00000);
      conv(3'h3, 3'h2, 0, 18'h00000);
      // late host: read with zeros, then one word, then run on
      repeat (24) txq.push_back(1'b0);
      put(8'hbf, 8);
      repeat (16) txq.push_back(1'b0);
      rd(1'b0);
      conv(3'h7, 3'h7, 2, 18'h3fff0);
      repeat (24) txq.push_back(1'b0);
      rd(1'b1);
      conv(3'h7, 3'h7, 0, 18'h00000);
      repeat (24) txq.push_back(1'b0);
      rd(1'b0);
      conv(3'h7, 3'h7, 0, 18'h00000);
      repeat (24) txq.push_back(1'b0);
      rd(1'b0);
      // seventeen valid words, reserved bit kept low
      for (i = 0; i < 16; i++)
         put({2'b10, 3'(i), 3'(i / 2)}, 8);
      put(8'hb6, 8);
      rd(1'b0);
      for (i = 0; i < 17; i++)
         conv(3'(i % 8), 3'((i % 16) / 2), 0, 18'h00000);
      results();
   end
endmodule
